// [common/sph_params.svh]
// Constants for the serial port with hard reset.
// Assumes inclusion by bare name from rtl files; definitions only.
`ifndef SPH_PARAMS_SVH
`define SPH_PARAMS_SVH

// Command word width and the bit that marks a read
`define SPH_CMD_W 8
`define SPH_RD_BIT 0
`define SPH_RD_VAL 1'b1

// Data word width and write-data FIFO depth
`define SPH_WORD_W 8
`define SPH_FIFO_DEPTH 16

// Bit counter value of the last bit in a word
`define SPH_LAST_BIT 3'h7

// Filler shifted out when no read data are offered
`define SPH_FILL_BYTE 8'h00

`endif

// [common/sph_pkg.sv]
// Types used by the serial port; its FIFO declares its own.
// Assumes sph_params.svh sits on the include path.
`include "sph_params.svh"

package sph_pkg;

  // Transfer phase inside one chip-select frame
  typedef enum logic [1:0] {
    SPH_IDLE,
    SPH_CMD,
    SPH_WRITE,
    SPH_READ
  } sph_phase_t;

  // Decoded command handed to the master-clock side
  typedef struct packed {
    logic rd;
    logic [`SPH_CMD_W-1:0] code;
  } sph_cmd_t;

  // Register state of the serial port outside its write-data FIFO
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic sdi_s1;
    logic sdi_s2;
    logic hrst_s1;
    logic hrst_s2;
    sph_phase_t phase;
    logic [`SPH_WORD_W-1:0] rx;
    logic [`SPH_WORD_W-1:0] tx;
    logic [2:0] cnt;
    logic sdo;
    logic sdo_oe;
    sph_cmd_t cmd;
    logic cmd_valid;
    logic mode11;
    logic [`SPH_WORD_W-1:0] wdata;
    logic wvalid;
    logic ovf;
    logic unf;
  } sph_state_t;

endpackage : sph_pkg

// [rtl/sph_fifo.sv]
// Write-data FIFO with a registered output stage.
// Assumes one clock, synchronous active-high reset, DEPTH a power of two.
`timescale 1ns/1ps

module sph_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic ov;
    logic [W-1:0] od;
  } sph_fifo_st_t;

  sph_fifo_st_t q;
  sph_fifo_st_t d;
  logic push;
  logic pull;

  // Output register counts as one of the DEPTH places
  assign in_ready_o = ((q.cnt + (AW+1)'(q.ov)) < (AW+1)'(DEPTH));
  assign out_valid_o = q.ov;
  assign out_data_o = q.od;
  assign push = in_valid_i & in_ready_o;
  assign pull = (q.cnt != '0) & (~q.ov | out_ready_i);

  always_comb begin
    d = q;
    if (out_ready_i & q.ov) begin
      d.ov = 1'b0;
    end
    if (pull) begin
      d.od = q.mem[q.rp];
      d.ov = 1'b1;
      d.rp = q.rp + 1'b1;
    end
    if (push) begin
      d.mem[q.wp] = in_data_i;
      d.wp = q.wp + 1'b1;
    end
    unique case ({push, pull})
      2'b10: d.cnt = q.cnt + 1'b1;
      2'b01: d.cnt = q.cnt - 1'b1;
      default: d.cnt = q.cnt;
    endcase
    if (clear_i) begin
      d = '0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule : sph_fifo

// [rtl/sph_serial_port.sv]
// Serial port of the converter front end, with its active-low hard reset.
// Assumes pins arrive asynchronously and the serial clock is at most a
// quarter of clk_sys_i, so every serial clock edge is seen by sampling.
`timescale 1ns/1ps
`include "sph_params.svh"

// Function
// - Chip select high means no serial activity and no transfer.
// - Chip select falling starts a transfer; its next rising edge ends it.
// - Hard reset low refuses all communication even with chip select low.
// - Serial input is sampled on each rising serial clock edge.
// - Serial output changes on each falling serial clock edge.
// - Both idle-low and idle-high clock framing work; change only when deselected.
// - Serial clock is asynchronous; it runs only during transfers.
// - Serial output stays high impedance while the command byte comes in.
// - Output high impedance for writes, deselect and hard reset.
// - Output driven only while a read command is processed.
// - Half-duplex: input and output bits never share clock periods.
// - First eight bits after selection form a read or write command.
// - Serial input ignored after a read command and while deselected.
// - Hard reset holds registers at defaults and stops internal clocks.
// - Analog biasing stays enabled throughout hard reset.
module sph_serial_port #(
  parameter int WORD_W = `SPH_WORD_W,
  parameter int FIFO_DEPTH = `SPH_FIFO_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic hard_rst_n_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  output logic cmd_valid_o,
  output logic [`SPH_CMD_W-1:0] cmd_o,
  output logic cmd_rd_o,
  output logic [WORD_W-1:0] wr_data_o,
  output logic wr_valid_o,
  input wire logic wr_ready_i,
  input wire logic [WORD_W-1:0] rd_data_i,
  input wire logic rd_valid_i,
  output logic rd_ready_o,
  output logic busy_o,
  output logic mode11_o,
  output logic overflow_o,
  output logic underrun_o,
  output logic clk_run_o,
  output logic in_clk_run_o,
  output logic bias_en_o
);

  localparam sph_pkg::sph_state_t RST_VAL = '{
    cs_s1: 1'b1,
    cs_s2: 1'b1,
    cs_s3: 1'b1,
    sck_s1: 1'b0,
    sck_s2: 1'b0,
    sck_s3: 1'b0,
    sdi_s1: 1'b0,
    sdi_s2: 1'b0,
    hrst_s1: 1'b0,
    hrst_s2: 1'b0,
    phase: sph_pkg::SPH_IDLE,
    rx: '0,
    tx: '0,
    cnt: '0,
    sdo: 1'b0,
    sdo_oe: 1'b0,
    cmd: '0,
    cmd_valid: 1'b0,
    mode11: 1'b0,
    wdata: '0,
    wvalid: 1'b0,
    ovf: 1'b0,
    unf: 1'b0
  };

  sph_pkg::sph_state_t q;
  sph_pkg::sph_state_t d;

  logic fifo_in_ready;
  logic run;
  logic sel;
  logic sel_fall;
  logic sck_rise;
  logic sck_fall;
  logic [WORD_W-1:0] shifted_in;

  // Read decode of a command word
  function automatic logic cmd_is_read(input logic [`SPH_CMD_W-1:0] c);
    cmd_is_read = (c[`SPH_RD_BIT] == `SPH_RD_VAL);
  endfunction : cmd_is_read

  // Next byte to send, or filler when none is offered
  function automatic logic [WORD_W-1:0] next_tx(
    input logic v,
    input logic [WORD_W-1:0] b
  );
    next_tx = v ? b : WORD_W'(`SPH_FILL_BYTE);
  endfunction : next_tx

  // Hard reset released and chip select low
  assign run = q.hrst_s2;
  assign sel = run & ~q.cs_s2;
  assign sel_fall = sel & q.cs_s3;
  assign sck_rise = q.sck_s2 & ~q.sck_s3;
  assign sck_fall = ~q.sck_s2 & q.sck_s3;
  assign shifted_in = {q.rx[WORD_W-2:0], q.sdi_s2};

  // Read data are taken at the command and after each sent word
  always_comb begin
    rd_ready_o = 1'b0;
    if (sel & sck_rise & (q.phase == sph_pkg::SPH_CMD)) begin
      rd_ready_o = (q.cnt == `SPH_LAST_BIT) & cmd_is_read(shifted_in);
    end else if (sel & sck_fall & (q.phase == sph_pkg::SPH_READ)) begin
      rd_ready_o = q.sdo_oe & (q.cnt == '0);
    end
  end

  always_comb begin
    d = q;
    // Pins pass two flops before any decision logic
    d.cs_s1 = cs_n_i;
    d.cs_s2 = q.cs_s1;
    d.cs_s3 = q.cs_s2;
    d.sck_s1 = sck_i;
    d.sck_s2 = q.sck_s1;
    d.sck_s3 = q.sck_s2;
    d.sdi_s1 = sdi_i;
    d.sdi_s2 = q.sdi_s1;
    d.hrst_s1 = hard_rst_n_i;
    d.hrst_s2 = q.hrst_s1;
    d.cmd_valid = 1'b0;
    d.wvalid = 1'b0;
    if (q.wvalid & ~fifo_in_ready) begin
      d.ovf = 1'b1;
    end
    if (!sel) begin
      // Deselected or in hard reset: no transfer, output released
      d.phase = sph_pkg::SPH_IDLE;
      d.sdo_oe = 1'b0;
      d.cnt = '0;
    end else if (sel_fall) begin
      // Idle clock level at selection gives the framing mode
      d.mode11 = q.sck_s2;
      d.phase = sph_pkg::SPH_CMD;
      d.cnt = '0;
      d.rx = '0;
      d.sdo_oe = 1'b0;
      d.ovf = 1'b0;
      d.unf = 1'b0;
    end else begin
      unique case (q.phase)
        sph_pkg::SPH_IDLE: begin
          d.phase = sph_pkg::SPH_IDLE;
        end
        sph_pkg::SPH_CMD: begin
          d.sdo_oe = 1'b0;
          if (sck_rise) begin
            d.rx = shifted_in;
            d.cnt = q.cnt + 1'b1;
            if (q.cnt == `SPH_LAST_BIT) begin
              d.cmd.code = shifted_in;
              d.cmd.rd = cmd_is_read(shifted_in);
              d.cmd_valid = 1'b1;
              if (cmd_is_read(shifted_in)) begin
                d.phase = sph_pkg::SPH_READ;
                d.tx = next_tx(rd_valid_i, rd_data_i);
                d.unf = ~rd_valid_i;
              end else begin
                d.phase = sph_pkg::SPH_WRITE;
              end
            end
          end
        end
        sph_pkg::SPH_WRITE: begin
          d.sdo_oe = 1'b0;
          if (sck_rise) begin
            d.rx = shifted_in;
            d.cnt = q.cnt + 1'b1;
            if (q.cnt == `SPH_LAST_BIT) begin
              d.wdata = shifted_in;
              d.wvalid = 1'b1;
            end
          end
        end
        sph_pkg::SPH_READ: begin
          // Input toggling has no effect; only falling edges act
          if (sck_fall) begin
            d.sdo_oe = 1'b1;
            d.sdo = q.tx[WORD_W-1];
            d.tx = {q.tx[WORD_W-2:0], 1'b0};
            d.cnt = q.cnt + 1'b1;
            if (q.sdo_oe & (q.cnt == '0)) begin
              d.sdo = rd_valid_i ? rd_data_i[WORD_W-1] : 1'b0;
              d.tx = next_tx(rd_valid_i, rd_data_i);
              d.tx = {d.tx[WORD_W-2:0], 1'b0};
              d.cnt = 3'h1;
              if (!rd_valid_i) begin
                d.unf = 1'b1;
              end
            end else if (!q.sdo_oe) begin
              d.cnt = 3'h1;
            end
          end
        end
      endcase
    end
    if (!run) begin
      // Hard reset returns every register except the pin synchronizers to its default
      d.phase = sph_pkg::SPH_IDLE;
      d.rx = '0;
      d.tx = '0;
      d.cnt = '0;
      d.sdo = 1'b0;
      d.sdo_oe = 1'b0;
      d.cmd = '0;
      d.cmd_valid = 1'b0;
      d.mode11 = 1'b0;
      d.wdata = '0;
      d.wvalid = 1'b0;
      d.ovf = 1'b0;
      d.unf = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      q <= RST_VAL;
    end else begin
      q <= d;
    end
  end

  // Received write words wait here for the master-clock side
  sph_fifo #(
    .W(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .clear_i(~run),
    .in_valid_i(q.wvalid),
    .in_data_i(q.wdata),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(wr_valid_o),
    .out_data_o(wr_data_o),
    .out_ready_i(wr_ready_i)
  );

  assign sdo_o = q.sdo;
  assign sdo_oe_o = q.sdo_oe;
  assign cmd_valid_o = q.cmd_valid;
  assign cmd_o = q.cmd.code;
  assign cmd_rd_o = q.cmd.rd;
  assign busy_o = (q.phase != sph_pkg::SPH_IDLE);
  assign mode11_o = q.mode11;
  assign overflow_o = q.ovf;
  assign underrun_o = q.unf;
  // Internal clock gate closes in hard reset; input stage keeps running
  assign clk_run_o = q.hrst_s2;
  assign in_clk_run_o = 1'b1;
  assign bias_en_o = 1'b1;

endmodule : sph_serial_port

// [bench/sph_host_model.sv]
// Host model: serial bus master on the chip select, clock and input pins.
// Assumes clk_sys_i at 40 MHz; a serial half period is four of its cycles.
`timescale 1ns/1ps
module sph_host_model (
  input wire logic clk_sys_i,
  input wire logic sdo_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic sdi_o
);
  logic m11_q = 1'b0;
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    sdi_o = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : wt
  // Idle level sets the mode, only while deselected
  task automatic start(input logic m11);
    m11_q = m11;
    sck_o <= m11;
    wt(4);
    cs_n_o <= 1'b0;
    wt(4);
  endtask : start
  task automatic stop();
    sck_o <= m11_q;
    wt(4);
    cs_n_o <= 1'b1;
    sdi_o <= ~sdi_o;
    wt(8);
  endtask : stop
  // Bit set while clock low, both sides take it at the rise
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck_o <= 1'b0;
      sdi_o <= tx[i];
      wt(4);
      sck_o <= 1'b1;
      rx[i] = sdo_i;
      wt(4);
    end
  endtask : xbyte
endmodule : sph_host_model

// [bench/sph_serial_port_asserts.sv]
// Checker for the serial port, bound to the ports of its top module.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/1ps
`include "sph_params.svh"
module sph_serial_port_asserts (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic hard_rst_n_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic sdo_o,
  input wire logic sdo_oe_o,
  input wire logic cmd_valid_o,
  input wire logic [`SPH_CMD_W-1:0] cmd_o,
  input wire logic cmd_rd_o,
  input wire logic rd_ready_o,
  input wire logic busy_o,
  input wire logic mode11_o,
  input wire logic clk_run_o,
  input wire logic in_clk_run_o,
  input wire logic bias_en_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  a_cs_idle: assert property (cs_n_i [*4] |-> !busy_o && !sdo_oe_o)
    else $error("activity while deselected");
  a_hrst_block: assert property (!hard_rst_n_i [*4] |-> !busy_o && !sdo_oe_o && !cmd_valid_o)
    else $error("activity in hard reset");
  a_hrst_gate: assert property (!hard_rst_n_i [*4] |-> !clk_run_o)
    else $error("clock runs in hard reset");
  a_run_gate: assert property (hard_rst_n_i [*5] |-> clk_run_o)
    else $error("clock stopped out of reset");
  a_bias_on: assert property (bias_en_o && in_clk_run_o)
    else $error("bias or input clock off");
  a_oe_read: assert property (sdo_oe_o |-> cmd_rd_o)
    else $error("output driven without read");
  a_oe_start: assert property ($rose(sdo_oe_o) |-> busy_o && !cmd_valid_o && !sck_i && !$past(sck_i, 2))
    else $error("output enabled off a fall");
  a_sdo_fall: assert property (sdo_oe_o && $past(sdo_oe_o) && $changed(sdo_o) |-> !sck_i && !$past(sck_i, 2))
    else $error("output changed off a fall");
  a_cmd_pulse: assert property (cmd_valid_o |=> !cmd_valid_o)
    else $error("command pulse too long");
  a_cmd_kind: assert property (cmd_valid_o |-> busy_o && sck_i && (cmd_rd_o == cmd_o[`SPH_RD_BIT]))
    else $error("command kind wrong");
  a_mode_hold: assert property (busy_o && $past(busy_o) |-> $stable(mode11_o))
    else $error("mode changed in frame");
  a_rd_take: assert property (rd_ready_o |=> busy_o && cmd_rd_o)
    else $error("read byte taken outside read");
endmodule : sph_serial_port_asserts
bind sph_serial_port sph_serial_port_asserts sph_serial_port_asserts_inst (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .hard_rst_n_i(hard_rst_n_i), .cs_n_i(cs_n_i),
  .sck_i(sck_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .cmd_valid_o(cmd_valid_o),
  .cmd_o(cmd_o), .cmd_rd_o(cmd_rd_o), .rd_ready_o(rd_ready_o), .busy_o(busy_o),
  .mode11_o(mode11_o), .clk_run_o(clk_run_o), .in_clk_run_o(in_clk_run_o),
  .bias_en_o(bias_en_o));

// [bench/test_serial_port_with_hard_reset.sv]
// Bench: host model on the pins, user side and FIFO drain driven here.
// Assumes the host model and the checker are compiled before this file.
`timescale 1ns/1ps
module test_serial_port_with_hard_reset;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic hard_rst_n_i = 1'b1;
  logic wr_ready_i = 1'b1;
  logic rd_valid_i = 1'b0;
  logic [7:0] rd_data_i = 8'h00;
  logic cs_n_i, sck_i, sdi_i, sdo_o, sdo_oe_o, cmd_valid_o, cmd_rd_o, wr_valid_o;
  logic rd_ready_o, busy_o, mode11_o, overflow_o, underrun_o, clk_run_o, in_clk_run_o;
  logic bias_en_o;
  logic [7:0] cmd_o, wr_data_o;
  logic [7:0] wq[$];
  logic [7:0] rq[$];
  int mismatches = 0;
  int check_count = 0;
  int n_cmd = 0;
  logic oe_seen = 1'b0;
  always #12.5 clk_sys_i = ~clk_sys_i;
  sph_host_model sph_host_model_inst (.clk_sys_i(clk_sys_i), .sdo_i(sdo_oe_o ? sdo_o : 1'bz),
    .cs_n_o(cs_n_i), .sck_o(sck_i), .sdi_o(sdi_i));
  sph_serial_port sph_serial_port_inst (.clk_sys_i, .rst_i, .hard_rst_n_i, .cs_n_i, .sck_i,
    .sdi_i, .sdo_o, .sdo_oe_o, .cmd_valid_o, .cmd_o, .cmd_rd_o, .wr_data_o, .wr_valid_o,
    .wr_ready_i, .rd_data_i, .rd_valid_i, .rd_ready_o, .busy_o, .mode11_o, .overflow_o,
    .underrun_o, .clk_run_o, .in_clk_run_o, .bias_en_o);
  always @(posedge clk_sys_i) begin
    if (cmd_valid_o === 1'b1) n_cmd++;
    if (sdo_oe_o === 1'b1) oe_seen = 1'b1;
    if (wr_valid_o === 1'b1 && wr_ready_i === 1'b1) wq.push_back(wr_data_o);
    if (rd_ready_o === 1'b1 && rd_valid_i === 1'b1) rd_data_i <= rd_data_i + 8'h11;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : wt
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Command byte, then nb bytes a0, a1, ... on the input pin
  task automatic frame(input logic m11, input logic [7:0] c, input int nb);
    logic [7:0] r;
    wq.delete();
    rq.delete();
    oe_seen = 1'b0;
    sph_host_model_inst.start(m11);
    sph_host_model_inst.xbyte(c, r);
    for (int i = 0; i < nb; i++) begin
      sph_host_model_inst.xbyte(8'ha0 + 8'(i), r);
      rq.push_back(r);
    end
    sph_host_model_inst.stop();
  endtask : frame
  task automatic t_write(input logic m11);
    int n0;
    n0 = n_cmd;
    frame(m11, 8'h42, 2);
    chk(16'(n_cmd - n0), 16'h0001);
    chk(cmd_o, 8'h42);
    chk(cmd_rd_o, 1'b0);
    chk(mode11_o, m11);
    chk(16'(wq.size()), 16'h0002);
    chk({wq[0], wq[1]}, 16'ha0a1);
    chk(oe_seen, 1'b0);
    chk(underrun_o, 1'b0);
  endtask : t_write
  task automatic t_read(input logic m11, input logic v);
    @(posedge clk_sys_i);
    rd_data_i <= 8'hc3;
    rd_valid_i <= v;
    frame(m11, 8'h41, 2);
    chk(cmd_rd_o, 1'b1);
    chk({rq[0], rq[1]}, v ? 16'hc3d4 : 16'h0000);
    chk(16'(wq.size()), 16'h0000);
    chk(underrun_o, !v);
    chk(mode11_o, m11);
  endtask : t_read
  task automatic t_idle();
    logic [7:0] r;
    int n0;
    n0 = n_cmd;
    sph_host_model_inst.xbyte(8'h42, r);
    sph_host_model_inst.stop();
    chk(16'(n_cmd - n0), 16'h0000);
    chk(busy_o, 1'b0);
  endtask : t_idle
  task automatic t_hrst();
    int n0;
    n0 = n_cmd;
    hard_rst_n_i <= 1'b0;
    wt(6);
    chk(clk_run_o, 1'b0);
    chk({in_clk_run_o, bias_en_o}, 16'h0003);
    chk(cmd_o, 8'h00);
    frame(1'b0, 8'h42, 1);
    chk(16'(n_cmd - n0), 16'h0000);
    chk(16'(wq.size()), 16'h0000);
    hard_rst_n_i <= 1'b1;
    wt(6);
    chk(clk_run_o, 1'b1);
  endtask : t_hrst
  // FIFO fills while the drain stalls, then empties
  task automatic t_ovf();
    wr_ready_i <= 1'b0;
    frame(1'b0, 8'h42, 17);
    chk(overflow_o, 1'b1);
    wr_ready_i <= 1'b1;
    wt(40);
    chk(16'(wq.size()), 16'h0010);
    chk(wq[15], 8'haf);
    chk(wr_valid_o, 1'b0);
  endtask : t_ovf
  task automatic end_sim();
    $display("Checks made %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    wt(6);
    rst_i <= 1'b0;
    wt(6);
    t_write(1'b0);
    t_write(1'b1);
    t_read(1'b0, 1'b1);
    t_read(1'b1, 1'b1);
    t_read(1'b0, 1'b0);
    t_write(1'b0);
    t_idle();
    t_hrst();
    t_ovf();
    end_sim();
  end
  initial begin
    #1000000;
    mismatches++;
    end_sim();
  end
endmodule : test_serial_port_with_hard_reset
